/* File: common/tiss_pkg.sv */
package tiss_pkg;
    // trigger select codes for the fourth timer
    typedef enum logic [1:0] {
        TISS_TRIG0 = 2'h0,
        TISS_TRIG1 = 2'h1,
        TISS_TRIG2 = 2'h2,
        TISS_TRIG_RSVD = 2'h3
    } tiss_trig_t;
    // one nibble of break selects, bit 3 is break input 0
    typedef logic [3:0] tiss_brk_t;
endpackage

/* File: common/tiss_regs.svh */
// What this block does
// - fourth timer trigger field picks trigger 0-2
// - first timer break sources, bits 21..18
// - second timer break sources, bits 17..14
// - third timer break sources, bits 9..6
// - fourth timer break sources, bits 5..2
// - bit 0 selects direct or XOR input
// - reset clears every select field
`ifndef TISS_REGS_SVH
`define TISS_REGS_SVH
// register address (byte offset)
`define TISS_SEL_ADDR 8'h2C
// reset value of the select register
`define TISS_SEL_RESET 32'h00000000
// implemented (writable) bits: 23:14, 9:2, 0
`define TISS_SEL_MASK 32'h00FFC3FD
// field positions
`define TISS_ETI3_HI 23
`define TISS_ETI3_LO 22
`define TISS_BRK0_HI 21
`define TISS_BRK0_LO 18
`define TISS_BRK1_HI 17
`define TISS_BRK1_LO 14
`define TISS_BRK2_HI 9
`define TISS_BRK2_LO 6
`define TISS_BRK3_HI 5
`define TISS_BRK3_LO 2
`define TISS_COMP_BIT 0
`endif

/* File: hdl/tiss_top.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "tiss_regs.svh"
module tiss_top (
    // clock and asynchronous active-low reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // register port: byte address, data, one-cycle strobes
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [31:0] o_rdata,
    // external trigger candidates for the fourth timer
    input wire logic [2:0] i_ext_trig,
    // break inputs from pins and trigger selector, index = timer*4+input
    input wire logic [15:0] i_brk_pin,
    input wire logic [15:0] i_brk_trigger_selector_unit,
    // channel pins feeding the complementary input selector
    input wire logic i_adv_ctl1_comp_ch_pin,
    input wire logic i_adv_ctl1_ch_pin,
    input wire logic i_adv_ctl0_ch_pin,
    // routed signals toward the four timers
    output logic o_adv_ctl3_ext_trig,
    output logic [15:0] o_brk,
    output logic o_adv_ctl1_comp_ch
);
    import tiss_pkg::*;

    // select register and its next value
    logic [31:0] sel_r; // stored select word, reserved bits zero
    logic [31:0] sel_nxt; // value the register takes at the next edge
    logic [31:0] rdata_nxt; // read data launched at the next edge
    // bus decode
    logic hit; // address matches the select word
    logic wr_hit; // write strobe at the select word
    logic rd_hit; // read strobe at the select word
    // select fields
    logic [1:0] adv_ctl3_ext_trig_source; // fourth timer trigger code
    tiss_brk_t adv_ctl0_brk_src; // first timer break selects
    tiss_brk_t adv_ctl1_brk_src; // second timer break selects
    tiss_brk_t adv_ctl2_brk_src; // third timer break selects
    tiss_brk_t adv_ctl3_brk_src; // fourth timer break selects
    logic adv_ctl1_comp_ch_source; // 1 picks the exclusive-or
    tiss_trig_t trig_sel; // trigger code as an enum
    logic [15:0] brk_sel; // break selects, index timer*4+input
    // next values of the routed outputs
    logic trig_nxt; // routed trigger
    wire logic [15:0] brk_nxt; // routed break inputs
    logic comp_nxt; // routed complementary input

    // address decode; only the word at the select offset is mapped
    assign hit = (i_addr == `TISS_SEL_ADDR);
    // strobes that reach the select word
    assign wr_hit = i_write && hit;
    assign rd_hit = i_read && hit;
    // full word write, reserved bits forced to zero
    assign sel_nxt = wr_hit ? (i_wdata & `TISS_SEL_MASK) : sel_r;
    // unmapped reads and idle cycles return zero
    assign rdata_nxt = rd_hit ? sel_r : 32'h00000000;

    // field extraction, one named wire per select field
    assign adv_ctl3_ext_trig_source = sel_r[`TISS_ETI3_HI:`TISS_ETI3_LO];
    assign adv_ctl0_brk_src = sel_r[`TISS_BRK0_HI:`TISS_BRK0_LO];
    assign adv_ctl1_brk_src = sel_r[`TISS_BRK1_HI:`TISS_BRK1_LO];
    assign adv_ctl2_brk_src = sel_r[`TISS_BRK2_HI:`TISS_BRK2_LO];
    assign adv_ctl3_brk_src = sel_r[`TISS_BRK3_HI:`TISS_BRK3_LO];
    assign adv_ctl1_comp_ch_source = sel_r[`TISS_COMP_BIT];
    // code as the trigger enum; the reserved code stays distinct
    assign trig_sel = tiss_trig_t'(adv_ctl3_ext_trig_source);
    // reorder so index timer*4+n maps break n of that timer
    // (within each nibble the high bit belongs to break input 0)
    assign brk_sel = {
        adv_ctl3_brk_src[0], adv_ctl3_brk_src[1],
        adv_ctl3_brk_src[2], adv_ctl3_brk_src[3],
        adv_ctl2_brk_src[0], adv_ctl2_brk_src[1],
        adv_ctl2_brk_src[2], adv_ctl2_brk_src[3],
        adv_ctl1_brk_src[0], adv_ctl1_brk_src[1],
        adv_ctl1_brk_src[2], adv_ctl1_brk_src[3],
        adv_ctl0_brk_src[0], adv_ctl0_brk_src[1],
        adv_ctl0_brk_src[2], adv_ctl0_brk_src[3]};

    // trigger mux; reserved code drives low so no stray trigger leaks
    always_comb begin
        case (trig_sel)
            // code 00: external trigger 0
            TISS_TRIG0: trig_nxt = i_ext_trig[0];
            // code 01: external trigger 1
            TISS_TRIG1: trig_nxt = i_ext_trig[1];
            // code 10: external trigger 2
            TISS_TRIG2: trig_nxt = i_ext_trig[2];
            // code 11 is reserved: hold the line quiet
            default: trig_nxt = 1'h0;
        endcase
    end

    // one two-way selector per break input: 0 pin, 1 trigger selector
    // a generate loop keeps the sixteen copies identical
    for (genvar g = 0; g < 16; g++) begin : g_brk
        assign brk_nxt[g] = brk_sel[g] ? i_brk_trigger_selector_unit[g] : i_brk_pin[g];
    end

    // complementary input, direct or three-way exclusive-or
    assign comp_nxt = adv_ctl1_comp_ch_source ?
        (i_adv_ctl1_ch_pin ^ i_adv_ctl1_comp_ch_pin ^ i_adv_ctl0_ch_pin) :
        i_adv_ctl1_comp_ch_pin;

    // register and read data
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_r <= `TISS_SEL_RESET;
            o_rdata <= 32'h00000000;
        end else begin
            sel_r <= sel_nxt;
            o_rdata <= rdata_nxt;
        end
    end

    // registered routed outputs, glitch free toward the timers
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_adv_ctl3_ext_trig <= 1'b0;
            o_brk <= 16'h0000;
            o_adv_ctl1_comp_ch <= 1'b0;
        end else begin
            o_adv_ctl3_ext_trig <= trig_nxt;
            o_brk <= brk_nxt;
            o_adv_ctl1_comp_ch <= comp_nxt;
        end
    end

    // all checks run on the bus clock and rest while reset is held
    default clocking cb_chk @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    // named steps of the register handshake
    // a write strobe at the select word
    sequence s_sel_write;
        i_write && hit;
    endsequence
    // a read strobe at the select word
    sequence s_sel_read;
        i_read && hit;
    endsequence
    // a read strobe that misses the select word
    sequence s_miss_read;
        i_read && !hit;
    endsequence

    // reserved bits never hold a one
    a_reserved_zero: assert property (
        (sel_r & ~`TISS_SEL_MASK) == 32'h00000000)
        else $error("reserved select bit set");
    // a write to the select word lands at its edge
    a_write_lands: assert property (
        s_sel_write |=> sel_r == ($past(i_wdata) & `TISS_SEL_MASK))
        else $error("write not stored");
    // a read returns the stored word one cycle later
    a_read_data: assert property (
        s_sel_read |=> o_rdata == $past(sel_r))
        else $error("read data wrong");
    // a read of any other address answers zero
    a_miss_read_zero: assert property (
        s_miss_read |=> o_rdata == 32'h00000000)
        else $error("unmapped read not zero");
    // read data fall back to zero when no read is made
    a_idle_rdata: assert property (
        !i_read |=> o_rdata == 32'h00000000)
        else $error("idle read data not zero");
    // a write elsewhere leaves the select word alone
    a_miss_write_kept: assert property (
        i_write && !hit |=> sel_r == $past(sel_r))
        else $error("unmapped write changed select");
    // with no write the select word holds
    a_no_write_kept: assert property (
        !i_write |=> $stable(sel_r))
        else $error("select changed without write");
    // read data never show a reserved bit
    a_read_masked: assert property (
        s_sel_read |=> (o_rdata & ~`TISS_SEL_MASK) == 32'h00000000)
        else $error("read shows reserved bit");

    // trigger routing for every code but the reserved one
    a_trig_route: assert property (
        trig_sel != TISS_TRIG_RSVD |=>
        o_adv_ctl3_ext_trig == $past(i_ext_trig[trig_sel]))
        else $error("trigger route wrong");
    // code 00 picks trigger 0
    a_trig0_route: assert property (
        trig_sel == TISS_TRIG0 |=>
        o_adv_ctl3_ext_trig == $past(i_ext_trig[0]))
        else $error("trigger 0 route wrong");
    // code 01 picks trigger 1
    a_trig1_route: assert property (
        trig_sel == TISS_TRIG1 |=>
        o_adv_ctl3_ext_trig == $past(i_ext_trig[1]))
        else $error("trigger 1 route wrong");
    // code 10 picks trigger 2
    a_trig2_route: assert property (
        trig_sel == TISS_TRIG2 |=>
        o_adv_ctl3_ext_trig == $past(i_ext_trig[2]))
        else $error("trigger 2 route wrong");
    // the reserved code keeps the trigger low
    a_trig_rsvd_low: assert property (
        trig_sel == TISS_TRIG_RSVD |=> !o_adv_ctl3_ext_trig)
        else $error("reserved trigger not low");

    // break routing, bit by bit and timer by timer
    a_brk_pin: assert property (
        !brk_sel[0] |=> o_brk[0] == $past(i_brk_pin[0]))
        else $error("break 0 pin route wrong");
    a_brk_trig: assert property (
        brk_sel[15] |=> o_brk[15] == $past(i_brk_trigger_selector_unit[15]))
        else $error("break 15 selector route wrong");
    a_brk_t1: assert property (
        sel_r[17] |=> o_brk[4] == $past(i_brk_trigger_selector_unit[4]))
        else $error("second timer break route wrong");
    a_brk_t2: assert property (
        sel_r[6] |=> o_brk[11] == $past(i_brk_trigger_selector_unit[11]))
        else $error("third timer break route wrong");
    // bit 21 steers break input 0 of the first timer
    a_brk_in0_order: assert property (
        sel_r[21] |=> o_brk[0] == $past(i_brk_trigger_selector_unit[0]))
        else $error("first timer input 0 order wrong");
    // bit 5 steers break input 0 of the fourth timer
    a_brk_t3_in0: assert property (
        sel_r[5] |=> o_brk[12] == $past(i_brk_trigger_selector_unit[12]))
        else $error("fourth timer input 0 order wrong");
    // every break output follows its own selector bit
    a_brk_vector: assert property (
        1'h1 |=> o_brk == $past((brk_sel & i_brk_trigger_selector_unit)
        | (~brk_sel & i_brk_pin)))
        else $error("break vector route wrong");
    // first timer, all breaks from pins
    a_t0_pins: assert property (
        adv_ctl0_brk_src == 4'h0 |=> o_brk[3:0] == $past(i_brk_pin[3:0]))
        else $error("first timer pin route wrong");
    // first timer, all breaks from the trigger selector
    a_t0_trigger_selector_unit: assert property (
        adv_ctl0_brk_src == 4'hF |=>
        o_brk[3:0] == $past(i_brk_trigger_selector_unit[3:0]))
        else $error("first timer selector route wrong");
    // second timer, all breaks from pins
    a_t1_pins: assert property (
        adv_ctl1_brk_src == 4'h0 |=> o_brk[7:4] == $past(i_brk_pin[7:4]))
        else $error("second timer pin route wrong");
    // second timer, all breaks from the trigger selector
    a_t1_trigger_selector_unit: assert property (
        adv_ctl1_brk_src == 4'hF |=>
        o_brk[7:4] == $past(i_brk_trigger_selector_unit[7:4]))
        else $error("second timer selector route wrong");
    // third timer, all breaks from pins
    a_t2_pins: assert property (
        adv_ctl2_brk_src == 4'h0 |=>
        o_brk[11:8] == $past(i_brk_pin[11:8]))
        else $error("third timer pin route wrong");
    // third timer, all breaks from the trigger selector
    a_t2_trigger_selector_unit: assert property (
        adv_ctl2_brk_src == 4'hF |=>
        o_brk[11:8] == $past(i_brk_trigger_selector_unit[11:8]))
        else $error("third timer selector route wrong");
    // fourth timer, all breaks from pins
    a_t3_pins: assert property (
        adv_ctl3_brk_src == 4'h0 |=>
        o_brk[15:12] == $past(i_brk_pin[15:12]))
        else $error("fourth timer pin route wrong");
    // fourth timer, all breaks from the trigger selector
    a_t3_trigger_selector_unit: assert property (
        adv_ctl3_brk_src == 4'hF |=>
        o_brk[15:12] == $past(i_brk_trigger_selector_unit[15:12]))
        else $error("fourth timer selector route wrong");

    // complementary input in both settings
    a_comp_xor: assert property (
        sel_r[0] |=> o_adv_ctl1_comp_ch == $past(i_adv_ctl1_ch_pin
        ^ i_adv_ctl1_comp_ch_pin ^ i_adv_ctl0_ch_pin))
        else $error("xor input wrong");
    a_comp_direct: assert property (
        !adv_ctl1_comp_ch_source |=>
        o_adv_ctl1_comp_ch == $past(i_adv_ctl1_comp_ch_pin))
        else $error("direct input wrong");

    // reset leaves a cleared select and quiet outputs
    a_reset_clear: assert property (
        $rose(i_resetn) |-> sel_r == 32'h00000000)
        else $error("select not cleared");
    a_reset_outputs: assert property (
        $rose(i_resetn) |-> o_brk == 16'h0000 && !o_adv_ctl3_ext_trig
        && !o_adv_ctl1_comp_ch && o_rdata == 32'h00000000)
        else $error("outputs not cleared");
    // first routed value after reset uses trigger 0
    a_reset_route: assert property (
        $rose(i_resetn) |=> o_adv_ctl3_ext_trig == $past(i_ext_trig[0]))
        else $error("reset trigger route wrong");
endmodule

/* File: test/tiss_far_model.sv */
`timescale 1ns/1ps
// far-side lines: pins, trigger selector and channel inputs
module tiss_far_model (
    input wire logic i_clock,
    output logic [2:0] o_ext_trig,
    output logic [15:0] o_brk_pin,
    output logic [15:0] o_brk_trigger_selector_unit,
    output logic [2:0] o_ch
);
    logic [15:0] n_r = 16'h0001; // shift pattern, moves every cycle
    // lines change just after each edge, never settle to one value
    always @(posedge i_clock) begin
        n_r <= {n_r[14:0], n_r[15] ^ n_r[13] ^ n_r[12] ^ n_r[10]};
    end
    assign o_brk_pin = n_r;
    assign o_brk_trigger_selector_unit = ~{n_r[7:0], n_r[15:8]};
    assign o_ext_trig = n_r[2:0] ^ n_r[9:7];
    assign o_ch = n_r[5:3]; // comp pin, second ch pin, first ch pin
endmodule

/* File: test/tiss_top_test.sv */
`timescale 1ns/1ps
`include "tiss_regs.svh"
module tiss_top_test;
    logic i_clock = 1'h0, i_resetn = 1'h0, i_write = 1'h0, i_read = 1'h0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, sel_e = 32'h0;
    logic [2:0] ext, ch, pe, pc; // live and sampled far-side lines
    logic [15:0] pin, trg, pp, pt, o_brk;
    logic o_ext, o_comp;
    int fail_count = 0, tests_run = 0;
    int hi[4] = '{21, 17, 9, 5}; // top bit of each timer's break nibble
    always #12.5 i_clock = ~i_clock;
    // what the design saw at the last edge
    always @(posedge i_clock) begin
        pe <= ext;
        pp <= pin;
        pt <= trg;
        pc <= ch;
    end
    tiss_far_model far (.i_clock(i_clock), .o_ext_trig(ext),
        .o_brk_pin(pin), .o_brk_trigger_selector_unit(trg), .o_ch(ch));
    tiss_top uut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .i_ext_trig(ext),
        .i_brk_pin(pin), .i_brk_trigger_selector_unit(trg),
        .i_adv_ctl1_comp_ch_pin(ch[2]), .i_adv_ctl1_ch_pin(ch[1]),
        .i_adv_ctl0_ch_pin(ch[0]), .o_adv_ctl3_ext_trig(o_ext),
        .o_brk(o_brk), .o_adv_ctl1_comp_ch(o_comp));
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe, whole word
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'h1;
        @(posedge i_clock);
        i_write <= 1'h0;
    endtask
    // read data is looked at in the one cycle after the strobe
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'h1;
        @(posedge i_clock);
        i_read <= 1'h0;
        #1 cmp("rdata", exp, o_rdata);
    endtask
    // routed outputs against the select value, one cycle behind inputs
    task automatic route(int n);
        logic [15:0] eb;
        repeat (2) @(posedge i_clock);
        repeat (n) begin
            @(negedge i_clock);
            for (int i = 0; i < 16; i++)
                eb[i] = sel_e[hi[i/4] - i%4] ? pt[i] : pp[i];
            cmp("brk", eb, o_brk);
            cmp("trig", sel_e[23:22] == 2'h3 ? 1'h0 : pe[sel_e[23:22]], o_ext);
            cmp("comp", sel_e[0] ? ^pc : pc[2], o_comp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // after reset: cleared select, pins and trigger 0
    task automatic scn_after_reset();
        rd(`TISS_SEL_ADDR, `TISS_SEL_RESET);
        route(6);
    endtask
    // every trigger code, break bits alternating, reserved bits zero
    task automatic scn_codes();
        for (int c = 0; c < 4; c++) begin
            sel_e = (c << 22) | (c[0] ? 32'h00154155 : 32'h002A82A8);
            wr(`TISS_SEL_ADDR, sel_e);
            rd(`TISS_SEL_ADDR, sel_e);
            route(8);
        end
    endtask
    // every writable bit set, then all cleared again
    task automatic scn_extremes();
        sel_e = `TISS_SEL_MASK;
        wr(`TISS_SEL_ADDR, sel_e);
        rd(`TISS_SEL_ADDR, sel_e);
        route(6);
        sel_e = 32'h00000000;
        wr(`TISS_SEL_ADDR, sel_e);
        route(6);
    endtask
    // unmapped place: write ignored, read gives zero
    task automatic scn_unmapped();
        wr(8'h2B, `TISS_SEL_MASK);
        rd(8'h2B, 32'h0);
        rd(`TISS_SEL_ADDR, sel_e);
    endtask
    // reset in mid-run: select and outputs return to the cleared state
    task automatic scn_reset_again();
        sel_e = `TISS_SEL_MASK;
        wr(`TISS_SEL_ADDR, sel_e);
        @(posedge i_clock);
        i_resetn <= 1'h0;
        @(posedge i_clock);
        #1 cmp("brk in reset", 32'h0, o_brk);
        cmp("trig in reset", 32'h0, o_ext);
        cmp("comp in reset", 32'h0, o_comp);
        @(posedge i_clock);
        i_resetn <= 1'h1;
        sel_e = 32'h00000000;
        rd(`TISS_SEL_ADDR, `TISS_SEL_RESET);
        route(4);
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'h1;
        scn_after_reset();
        scn_codes();
        scn_extremes();
        scn_unmapped();
        scn_reset_again();
        summarize();
    end
endmodule
